// ### common/strd_pkg.sv
// constants and types shared by both ends of the supervisor trap decoder
// assumes one clock domain at 100 MHz shared by the slave cpu and the decoder
package strd_pkg;

    // slave i/o ports reserved for traps: highest port is trap one
    localparam logic [7:0]  TRAP_PORT_FIRST = 8'hF7;
    localparam logic [7:0]  TRAP_PORT_LAST  = 8'hF2;
    localparam logic [2:0]  TRAP_COUNT      = 3'h6;

    // per-trap pointer locations in slave memory, two bytes apart
    localparam logic [15:0] PTR_LOC_BASE    = 16'h0040;
    localparam logic [15:0] PTR_LOC_STRIDE  = 16'h0002;

    // handler location in master memory; arbitrary default
    localparam logic [15:0] HANDLER_VECTOR  = 16'h0100;

    // no-operation opcode of the slave; arbitrary default
    localparam logic [7:0]  NOP_OPCODE      = 8'h00;

    // request block: eight bytes inside the first 16k page of slave memory
    localparam logic [15:0] BLOCK_PAGE_LIMIT      = 16'h4000;
    localparam logic [2:0]  BLOCK_BYTES_M1        = 3'h7;
    localparam logic [2:0]  OFS_FUNCTION_CODE     = 3'h0;
    localparam logic [2:0]  OFS_CHANNEL_NUMBER    = 3'h1;
    localparam logic [2:0]  OFS_STATUS            = 3'h2;
    localparam logic [2:0]  OFS_SINGLE_DATA       = 3'h3;
    localparam logic [2:0]  OFS_TRANSFER_COUNT    = 3'h4;
    localparam logic [2:0]  OFS_BUFFER_LENGTH     = 3'h5;
    localparam logic [2:0]  OFS_BUFFER_POINTER_HI = 3'h6;
    localparam logic [2:0]  OFS_BUFFER_POINTER_LO = 3'h7;

    typedef enum logic [1:0] {
        STRD_IDLE  = 2'b00,
        STRD_ARMED = 2'b01,
        STRD_HALT  = 2'b10
    } strd_dev_state_t;

    typedef enum logic [1:0] {
        STRD_H_IDLE = 2'b00,
        STRD_H_IO   = 2'b01,
        STRD_H_NOP  = 2'b10,
        STRD_H_WAIT = 2'b11
    } strd_cpu_state_t;

endpackage : strd_pkg

// ### common/strd_if.sv
// slave cpu bus as seen by the trap decoder
// assumes both ends run on clk; the testbench instantiates and joins them
`timescale 1ns/10ps
interface strd_if (
    input wire logic clk
);
    logic       io_strobe;
    logic [7:0] io_port;
    logic       fetch_strobe;
    logic [7:0] fetch_opcode;
    logic       halt;

    modport dev (
        input  io_strobe,
        input  io_port,
        input  fetch_strobe,
        input  fetch_opcode,
        output halt
    );

    modport cpu (
        output io_strobe,
        output io_port,
        output fetch_strobe,
        output fetch_opcode,
        input  halt
    );
endinterface : strd_if

// ### hdl/strd_decoder.sv
// trap decoder on the debug card: watches the slave cpu bus, halts the slave
// and interrupts the master until the master reports the trap serviced
// assumes the slave bus and the master handshake share clk with this block
`timescale 1ns/10ps
module strd_decoder (
    input  wire logic        clk,
    input  wire logic        sys_rst,
    strd_if.dev              bus,
    input  wire logic        service_done,
    output logic             master_irq,
    output logic [15:0]      handler_vector,
    output logic [2:0]       trap_number,
    output logic [15:0]      pointer_location,
    output logic             trap_abandoned,
    output logic             trap_released,
    output logic [7:0]       traps_served
);

    typedef struct packed {
        strd_pkg::strd_dev_state_t state;
        logic [2:0]                armed_trap;
        logic                      halt;
        logic                      irq;
        logic [15:0]               vector;
        logic [2:0]                trap;
        logic [15:0]               ptr_loc;
        logic                      abandoned;
        logic                      released;
        logic [7:0]                served;
    } strd_dev_regs_t;

    strd_dev_regs_t r;
    strd_dev_regs_t next_r;

    // one comparator per reserved port; bit i stands for trap i+1,
    // everything else on the port bus is ordinary slave i/o
    logic [5:0] port_hit;
    logic       trap_io;

    genvar gi;
    generate
        for (gi = 0; gi < int'(strd_pkg::TRAP_COUNT); gi = gi + 1) begin : g_port_hit
            assign port_hit[gi] =
                (bus.io_port == (strd_pkg::TRAP_PORT_FIRST - 8'(gi)));
        end
    endgenerate

    // only a strobed cycle counts; the port value lingers after the strobe
    assign trap_io = bus.io_strobe && (port_hit != 6'h00);

    // f7 -> 1, f6 -> 2 ... f2 -> 6; at most one bit is ever set
    function automatic logic [2:0] trap_of_hit(input logic [5:0] hit);
        trap_of_hit = 3'h0;
        for (int i = 0; i < 6; i++) begin
            if (hit[i]) begin
                trap_of_hit = 3'(i + 1);
            end
        end
    endfunction : trap_of_hit

    // pointer location that the master must read for a trap
    function automatic logic [15:0] ptr_of_trap(input logic [2:0] trap);
        logic [15:0] idx;
        idx = {13'h0000, trap - 3'h1};
        ptr_of_trap = strd_pkg::PTR_LOC_BASE + (strd_pkg::PTR_LOC_STRIDE * idx);
    endfunction : ptr_of_trap

    always_comb begin
        next_r           = r;
        next_r.abandoned = 1'b0;
        next_r.released  = 1'b0;
        next_r.vector    = strd_pkg::HANDLER_VECTOR;
        case (r.state)
            strd_pkg::STRD_IDLE: begin
                if (trap_io) begin
                    next_r.armed_trap = trap_of_hit(port_hit);
                    next_r.state      = strd_pkg::STRD_ARMED;
                end
            end
            strd_pkg::STRD_ARMED: begin
                // a fresh trap-port i/o re-arms; the pair may be split by cycles without a strobe
                if (trap_io) begin
                    next_r.armed_trap = trap_of_hit(port_hit);
                end else if (bus.io_strobe) begin
                    next_r.abandoned = 1'b1;
                    next_r.state     = strd_pkg::STRD_IDLE;
                end else if (bus.fetch_strobe) begin
                    if (bus.fetch_opcode == strd_pkg::NOP_OPCODE) begin
                        next_r.halt    = 1'b1;
                        next_r.irq     = 1'b1;
                        next_r.trap    = r.armed_trap;
                        next_r.ptr_loc = ptr_of_trap(r.armed_trap);
                        next_r.state   = strd_pkg::STRD_HALT;
                    end else begin
                        // any other instruction means plain port i/o
                        next_r.abandoned = 1'b1;
                        next_r.state     = strd_pkg::STRD_IDLE;
                    end
                end
            end
            strd_pkg::STRD_HALT: begin
                // halt holds until the master says done, not on irq ack,
                // so the master may touch slave memory at leisure
                if (service_done) begin
                    next_r.halt     = 1'b0;
                    next_r.irq      = 1'b0;
                    next_r.released = 1'b1;
                    next_r.served   = r.served + 8'h01;
                    next_r.state    = strd_pkg::STRD_IDLE;
                end else begin
                    next_r.halt = 1'b1;
                end
            end
            default: begin
                next_r.state = strd_pkg::STRD_IDLE;
                next_r.halt  = 1'b0;
                next_r.irq   = 1'b0;
            end
        endcase
    end

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            r.state      <= strd_pkg::STRD_IDLE;
            r.armed_trap <= 3'h0;
            r.halt       <= 1'b0;
            r.irq        <= 1'b0;
            r.vector     <= strd_pkg::HANDLER_VECTOR;
            r.trap       <= 3'h0;
            r.ptr_loc    <= 16'h0000;
            r.abandoned  <= 1'b0;
            r.released   <= 1'b0;
            r.served     <= 8'h00;
        end else begin
            r <= next_r;
        end
    end

    assign bus.halt         = r.halt;
    assign master_irq       = r.irq;
    assign handler_vector   = r.vector;
    assign trap_number      = r.trap;
    assign pointer_location = r.ptr_loc;
    assign trap_abandoned   = r.abandoned;
    assign trap_released    = r.released;
    assign traps_served     = r.served;

endmodule : strd_decoder

// ### hdl/strd_slave_cpu.sv
// slave cpu end: issues trap sequences and ordinary instruction fetches
// assumes the decoder answers on the same clk; the request block is already in memory
`timescale 1ns/10ps
module strd_slave_cpu (
    input  wire logic        clk,
    input  wire logic        sys_rst,
    strd_if.cpu              bus,
    input  wire logic        trap_req,
    input  wire logic [2:0]  trap_sel,
    input  wire logic        fetch_req,
    input  wire logic [7:0]  fetch_op,
    output logic             busy,
    output logic             trap_done
);

    typedef struct packed {
        strd_pkg::strd_cpu_state_t state;
        logic                      io_strobe;
        logic [7:0]                io_port;
        logic                      fetch_strobe;
        logic [7:0]                fetch_opcode;
        logic                      seen_halt;
        logic                      busy;
        logic                      done;
    } strd_cpu_regs_t;

    strd_cpu_regs_t r;
    strd_cpu_regs_t next_r;

    always_comb begin
        next_r              = r;
        next_r.io_strobe    = 1'b0;
        next_r.fetch_strobe = 1'b0;
        next_r.done         = 1'b0;
        case (r.state)
            strd_pkg::STRD_H_IDLE: begin
                // trap selects outside 1..6 are ignored; ordinary fetches stall while halted
                if (trap_req && (trap_sel != 3'h0) && (trap_sel <= strd_pkg::TRAP_COUNT)) begin
                    next_r.io_strobe = 1'b1;
                    next_r.io_port   = strd_pkg::TRAP_PORT_FIRST - {5'h00, trap_sel - 3'h1};
                    next_r.busy      = 1'b1;
                    next_r.seen_halt = 1'b0;
                    next_r.state     = strd_pkg::STRD_H_IO;
                end else if (fetch_req && !bus.halt) begin
                    next_r.fetch_strobe = 1'b1;
                    next_r.fetch_opcode = fetch_op;
                end
            end
            strd_pkg::STRD_H_IO: begin
                next_r.fetch_strobe = 1'b1;
                next_r.fetch_opcode = strd_pkg::NOP_OPCODE;
                next_r.state        = strd_pkg::STRD_H_NOP;
            end
            strd_pkg::STRD_H_NOP: begin
                next_r.state = strd_pkg::STRD_H_WAIT;
            end
            strd_pkg::STRD_H_WAIT: begin
                if (bus.halt) begin
                    next_r.seen_halt = 1'b1;
                end else if (r.seen_halt) begin
                    next_r.busy  = 1'b0;
                    next_r.done  = 1'b1;
                    next_r.state = strd_pkg::STRD_H_IDLE;
                end
            end
            default: begin
                next_r.state = strd_pkg::STRD_H_IDLE;
                next_r.busy  = 1'b0;
            end
        endcase
    end

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            r.state        <= strd_pkg::STRD_H_IDLE;
            r.io_strobe    <= 1'b0;
            r.io_port      <= 8'h00;
            r.fetch_strobe <= 1'b0;
            r.fetch_opcode <= 8'h00;
            r.seen_halt    <= 1'b0;
            r.busy         <= 1'b0;
            r.done         <= 1'b0;
        end else begin
            r <= next_r;
        end
    end

    assign bus.io_strobe    = r.io_strobe;
    assign bus.io_port      = r.io_port;
    assign bus.fetch_strobe = r.fetch_strobe;
    assign bus.fetch_opcode = r.fetch_opcode;
    assign busy             = r.busy;
    assign trap_done        = r.done;

endmodule : strd_slave_cpu

// ### tb/strd_sva.sv
// bus checker for the trap decoder
// assumes the bench instantiates it beside the interface
`timescale 1ns/10ps
module strd_sva (
    input wire logic       clk,
    input wire logic       sys_rst,
    input wire logic       io_strobe,
    input wire logic [7:0] io_port,
    input wire logic       fetch_strobe,
    input wire logic [7:0] fetch_opcode,
    input wire logic       halt
);
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (sys_rst);
    logic tp;
    assign tp = io_port inside {[strd_pkg::TRAP_PORT_LAST:strd_pkg::TRAP_PORT_FIRST]};
    chk_trap_halts:
    assert property (io_strobe && tp ##1 fetch_strobe
        && fetch_opcode == strd_pkg::NOP_OPCODE |=> halt)
        else $error("trap pair did not halt");
    chk_halt_cause:
    assert property ($rose(halt) |-> $past(io_strobe, 2) && $past(tp, 2)
        && $past(fetch_strobe) && $past(fetch_opcode) == strd_pkg::NOP_OPCODE)
        else $error("halt without trap pair");
    chk_plain_io:
    assert property (io_strobe && !tp |-> ##2 !$rose(halt))
        else $error("halt on plain port");
    chk_halt_quiet:
    assert property (halt |-> !io_strobe && !fetch_strobe)
        else $error("bus active while halted");
    chk_io_pulse:
    assert property (io_strobe |=> !io_strobe)
        else $error("io strobe too long");
    chk_nop_follows:
    assert property (io_strobe && tp |=> fetch_strobe
        && fetch_opcode == strd_pkg::NOP_OPCODE)
        else $error("no nop after trap port");
    chk_resume_gap:
    assert property ($fell(halt) |-> !halt [*3])
        else $error("halt rose again at once");
    chk_port_holds:
    assert property (!io_strobe |-> $stable(io_port))
        else $error("port moved without strobe");
    cover property ($rose(halt));
    cover property ($fell(halt));
    cover property (io_strobe && io_port == strd_pkg::TRAP_PORT_LAST ##1 fetch_strobe);
endmodule : strd_sva

// ### tb/test_supervisor_trap_decoder.sv
// self-checking bench: slave cpu end and decoder joined by the bus interface
// assumes package, interface and both ends are compiled first
`timescale 1ns/10ps
module test_supervisor_trap_decoder;
    logic        clk = 0;
    logic        sys_rst = 1;
    logic        trap_req = 0;
    logic        fetch_req = 0;
    logic        service_done = 0;
    logic [2:0]  trap_sel = 0;
    logic [7:0]  fetch_op = 0;
    logic [7:0]  traps_served;
    logic [15:0] handler_vector;
    logic [15:0] pointer_location;
    logic [2:0]  trap_number;
    logic        master_irq;
    logic        trap_released;
    logic        trap_abandoned;
    logic        busy;
    logic        trap_done;
    int          err_count = 0;
    int          n_checks = 0;
    int          served = 0;
    logic [31:0] seed = 32'h0000_000D;
    logic [31:0] r;
    int          exp_q[$];
    int          exp_fc [1:6];
    logic [7:0]  smem [0:255];

    always #5 clk = ~clk;

    strd_if bus_if (.clk(clk));
    strd_decoder i_strd_decoder (.clk(clk), .sys_rst(sys_rst), .bus(bus_if),
        .service_done(service_done), .master_irq(master_irq),
        .handler_vector(handler_vector), .trap_number(trap_number),
        .pointer_location(pointer_location), .trap_abandoned(trap_abandoned),
        .trap_released(trap_released), .traps_served(traps_served));
    strd_slave_cpu i_strd_slave_cpu (.clk(clk), .sys_rst(sys_rst), .bus(bus_if),
        .trap_req(trap_req), .trap_sel(trap_sel), .fetch_req(fetch_req),
        .fetch_op(fetch_op), .busy(busy), .trap_done(trap_done));
    strd_sva i_strd_sva (.clk(clk), .sys_rst(sys_rst), .io_strobe(bus_if.io_strobe),
        .io_port(bus_if.io_port), .fetch_strobe(bus_if.fetch_strobe),
        .fetch_opcode(bus_if.fetch_opcode), .halt(bus_if.halt));

    function automatic logic [31:0] rnd();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction : rnd

    task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] g);
        n_checks++;
        if (g !== e) begin
            err_count++;
            $display("BAD %s exp %h got %h", nm, e, g);
        end
    endtask : chk

    task automatic end_sim();
        $display("checks %0d errors %0d", n_checks, err_count);
        if (err_count == 0 && n_checks > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask : end_sim

    // user software: one eight-byte block per trap, its pointer kept high byte first
    task automatic place_blocks();
        logic [15:0] blk;
        logic [15:0] loc;
        for (int t = 1; t <= 6; t++) begin
            blk = 16'h0080 + 16'(8 * (t - 1));
            loc = strd_pkg::PTR_LOC_BASE + strd_pkg::PTR_LOC_STRIDE * 16'(t - 1);
            r = rnd();
            exp_fc[t] = int'(r[7:0]);
            smem[loc] = blk[15:8];
            smem[loc + 16'h0001] = blk[7:0];
            smem[blk + 16'(strd_pkg::OFS_FUNCTION_CODE)] = r[7:0];
        end
    endtask : place_blocks

    // one full trap: issue, check decode, master reads the block, hold dly cycles, service
    task automatic do_trap(input int n, input int dly);
        int          k;
        int          t;
        logic [15:0] blk;
        logic [15:0] e_ptr;
        logic [7:0]  e_port;
        logic [7:0]  fc;
        logic        in_page;
        exp_q.push_back(n);
        trap_req = 1;
        trap_sel = n[2:0];
        @(negedge clk);
        trap_req = 0;
        k = 0;
        while (bus_if.halt !== 1'b1 && k < 20) begin
            @(negedge clk);
            k++;
        end
        if (k == 20) begin
            err_count++;
            $display("BAD halt_wait exp 1 got 0");
            end_sim();
        end
        t = exp_q.pop_front();
        e_port = strd_pkg::TRAP_PORT_FIRST - 8'(t - 1);
        e_ptr = strd_pkg::PTR_LOC_BASE + strd_pkg::PTR_LOC_STRIDE * 16'(t - 1);
        chk("halt_delay", 16'h0002, k[15:0]);
        chk("irq", 16'h0001, {15'h0, master_irq});
        chk("io_port", {8'h00, e_port}, {8'h00, bus_if.io_port});
        chk("trap_number", 16'(t), {13'h0, trap_number});
        chk("pointer", e_ptr, pointer_location);
        chk("vector", strd_pkg::HANDLER_VECTOR, handler_vector);
        // master side: a wrong pointer lands on unwritten bytes and shows up here
        blk = {smem[pointer_location], smem[pointer_location + 16'h0001]};
        in_page = (blk + 16'(strd_pkg::BLOCK_BYTES_M1)) < strd_pkg::BLOCK_PAGE_LIMIT;
        fc = smem[blk + 16'(strd_pkg::OFS_FUNCTION_CODE)];
        chk("block_page", 16'h0001, {15'h0, in_page});
        chk("function_code", 16'(exp_fc[t]), {8'h00, fc});
        repeat (dly) begin
            @(negedge clk);
            chk("held", 16'h0003, {14'h0, bus_if.halt, master_irq});
        end
        service_done = 1;
        @(negedge clk);
        service_done = 0;
        served++;
        chk("release", 16'h0003, {14'h0, trap_released, ~bus_if.halt});
        chk("served", served[15:0] & 16'h00FF, {8'h00, traps_served});
        @(negedge clk);
        chk("done", 16'h0002, {14'h0, trap_done, busy});
    endtask : do_trap

    initial begin
        repeat (6) @(negedge clk);
        sys_rst = 0;
        chk("rst_vector", strd_pkg::HANDLER_VECTOR, handler_vector);
        chk("rst_state", 16'h0000, {11'h0, bus_if.halt, master_irq, trap_number});
        place_blocks();
        // back to back traps, every port, random service time
        for (int p = 0; p < 2; p++) begin
            for (int n = 1; n <= 6; n++) begin
                r = rnd();
                do_trap(n, int'(r % 6));
            end
        end
        // stray fetches, bad selects and idle service pulses must not halt
        for (int i = 0; i < 24; i++) begin
            r = rnd();
            fetch_req = ~r[0];
            fetch_op = r[15:8] & {8{r[1]}};
            trap_req = r[0];
            trap_sel = {3{r[2]}};
            service_done = r[3];
            @(negedge clk);
            chk("no_halt", 16'h0000, {13'h0, bus_if.halt, busy, trap_abandoned});
        end
        fetch_req = 0;
        trap_req = 0;
        service_done = 0;
        @(negedge clk);
        chk("idle_served", served[15:0], {8'h00, traps_served});
        // reset while the slave is held: both ends drop back to idle
        trap_req = 1;
        trap_sel = 3'h3;
        @(negedge clk);
        trap_req = 0;
        repeat (2) @(negedge clk);
        chk("pre_rst_halt", 16'h0001, {15'h0, bus_if.halt});
        sys_rst = 1;
        repeat (2) @(negedge clk);
        sys_rst = 0;
        served = 0;
        chk("mid_rst", 16'h0000, {5'h0, bus_if.halt, master_irq, busy, traps_served});
        @(negedge clk);
        do_trap(6, 3);
        end_sim();
    end
endmodule : test_supervisor_trap_decoder
